// ### pdrc_device.sv
// Function
// RULE1: powerdown freezes core and peripheral phase clocks
// RULE2: no dma, refresh, hold grants in powerdown
// RULE3: enter on halt ended by ready, mode set
// RULE4: indicator rises as clocks stop, pin function
// RULE5: indicator falls aligned to input clock
// RULE6: system blocks dma/hold using indicator
// RULE7: reset held high at least sixteen cycles
// RULE8: reset floats bidirectional pins immediately
// RULE9: synchronous internal reset for all peripherals
// RULE10: phase generator resets, then alternates 0/1
// RULE11: phase generator from state 3 goes 0
// RULE12: active wake-up level blocks idle/powerdown entry
// RULE13: no dram refresh in powerdown
// RULE14: powerdown freezes prescaled and baud clocks
// RULE15: idle freezes core clocks only
// RULE16: two-bit mode field selects idle/powerdown/active
// RULE17: wake-up restarts clocks, then drops indicator; code drops it on the same edge the clocks restart
// RULE18: reset clears mode and exits low power
`timescale 1ns/10ps
module pdrc_device
   import pdrc_pkg::*;
(
   input wire logic mclk,
   input wire logic sys_rst,
   pdrc_if.dev link,
   input wire logic mode_wr,
   input wire logic [1:0] mode_wdata,
   output logic [1:0] power_mode_select,
   input wire logic halt_cycle,
   input wire logic ready_n,
   input wire logic shared_port_pin_periph,
   input wire logic shared_port_gpio,
   input wire logic core_drive,
   input wire logic core_dout,
   output logic core_phase_one_clock,
   output logic core_phase_two_clock,
   output logic periph_phase_one_clock,
   output logic periph_phase_two_clock,
   output logic prescaled_clock,
   output logic serial_baud_clock,
   output logic periph_rst,
   output logic in_idle,
   output logic in_powerdown
);
   // power states; wake restarts the clocks on the same edge the indicator drops
   typedef enum logic [1:0] {
      st_run,
      st_idle,
      st_down,
      st_wake
   } pdrc_state_type;

   pdrc_state_type state;
   logic wake;
   logic enter;
   logic phase;
   logic core_run;
   logic periph_run;
   logic [8:0] psc_cnt;
   logic [7:0] baud_cnt;
   logic rst_meta;
   logic pin_out;

   // level-sensitive wake-up sources
   assign wake = link.wake_int | link.wake_nmi | ~link.system_mgmt_irq_n;
   // halt ended by external ready with no wake-up active
   assign enter = halt_cycle & ~ready_n & ~wake; // [RULE3] [RULE12]

   // synchronous internal peripheral reset
   always_ff @(posedge mclk) begin
      rst_meta <= sys_rst;
      periph_rst <= rst_meta | sys_rst; // [RULE9]
   end

   // power mode field
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         power_mode_select <= pdrc_mode_reset; // [RULE18]
      end else if (mode_wr) begin
         power_mode_select <= mode_wdata;
      end
   end

   // power state machine
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         state <= st_run; // [RULE18]
      end else begin
         unique case (state)
            st_run: begin
               if (enter && power_mode_select == pdrc_mode_idle) begin
                  state <= st_idle; // [RULE16]
               end else if (enter &&
                            power_mode_select == pdrc_mode_sleep_indicator_out) begin
                  state <= st_down; // [RULE3] [RULE16]
               end
            end
            st_idle: begin
               if (wake) begin
                  state <= st_run;
               end
            end
            st_down: begin
               if (wake) begin
                  state <= st_wake; // [RULE17]
               end
            end
            st_wake: begin
               // clocks restart and indicator drops on the first edge here
               if (phase) begin
                  state <= st_run; // [RULE5]
               end
            end
         endcase
      end
   end

   // clock run enables decoded from the power state
   assign core_run = (state == st_run) || (state == st_wake);
   assign periph_run = (state != st_down); // [RULE1]
   assign in_idle = (state == st_idle);
   assign in_powerdown = (state == st_down);

   // phase generator: 0 = phase one, 1 = phase two
   always_ff @(posedge mclk) begin
      if (periph_rst) begin
         phase <= 1'b0;
      end else if (periph_run) begin
         phase <= ~phase;
      end
   end

   // phase clocks: frozen ones hold phase one low, phase two high
   always_ff @(posedge mclk) begin
      if (periph_rst) begin
         core_phase_one_clock <= 1'b0;
         core_phase_two_clock <= 1'b1;
         periph_phase_one_clock <= 1'b0;
         periph_phase_two_clock <= 1'b1;
      end else begin
         core_phase_one_clock <= core_run & ~phase; // [RULE1] [RULE15]
         core_phase_two_clock <= ~core_run | phase; // [RULE1] [RULE15]
         periph_phase_one_clock <= periph_run & ~phase; // [RULE1]
         periph_phase_two_clock <= ~periph_run | phase; // [RULE1]
      end
   end

   // prescaled and baud clocks, frozen in powerdown
   always_ff @(posedge mclk) begin
      if (periph_rst) begin
         psc_cnt <= 9'h000;
         prescaled_clock <= 1'b0;
      end else if (periph_run) begin // [RULE14]
         if (psc_cnt == pdrc_psc_div) begin
            psc_cnt <= 9'h000;
            prescaled_clock <= ~prescaled_clock;
         end else begin
            psc_cnt <= psc_cnt + 9'h001;
         end
      end
   end

   // baud divider, same freeze as the prescaler
   always_ff @(posedge mclk) begin
      if (periph_rst) begin
         baud_cnt <= 8'h00;
         serial_baud_clock <= 1'b0;
      end else if (periph_run) begin // [RULE14]
         if (baud_cnt == pdrc_baud_div) begin
            baud_cnt <= 8'h00;
            serial_baud_clock <= ~serial_baud_clock;
         end else begin
            baud_cnt <= baud_cnt + 8'h01;
         end
      end
   end

   // grants blocked while peripheral clocks are frozen
   always_ff @(posedge mclk) begin
      if (periph_rst) begin
         link.dma_grant <= 1'b0;
         link.hold_grant <= 1'b0;
         link.refresh_ack <= 1'b0;
      end else begin
         link.dma_grant <= link.dma_req & periph_run; // [RULE2]
         link.hold_grant <= link.hold_req & periph_run; // [RULE2]
         link.refresh_ack <= link.refresh_req & periph_run; // [RULE13]
      end
   end

   // indicator: rises when clocks stop, falls on an input clock edge
   always_ff @(posedge mclk) begin
      if (sys_rst) begin
         pin_out <= 1'b0;
      end else if (shared_port_pin_periph) begin
         pin_out <= (state == st_down); // [RULE4] [RULE5] [RULE17]
      end else begin
         pin_out <= shared_port_gpio;
      end
   end
   assign link.sleep_indicator_out = pin_out;

   // bidirectional pin released at once by reset
   assign link.data_oe = core_drive & ~sys_rst; // [RULE8]
   assign link.data_out = core_dout;
endmodule : pdrc_device

// ### pdrc_pkg.sv
package pdrc_pkg;
   // power mode field encodings
   localparam logic [1:0] pdrc_mode_active0 = 2'h0;
   localparam logic [1:0] pdrc_mode_idle = 2'h1;
   localparam logic [1:0] pdrc_mode_sleep_indicator_out = 2'h2;
   localparam logic [1:0] pdrc_mode_active3 = 2'h3;
   localparam logic [1:0] pdrc_mode_reset = 2'h0;
   // reset input must stand this many input clock cycles
   localparam int pdrc_reset_min_cycles = 16;
   localparam logic [4:0] pdrc_reset_cnt_max = 5'h10;
   // phase generator state codes
   localparam logic [1:0] pdrc_ph_st0 = 2'h0;
   localparam logic [1:0] pdrc_ph_st1 = 2'h1;
   localparam logic [1:0] pdrc_ph_st3 = 2'h3;
   // prescaler and baud divider defaults
   localparam logic [8:0] pdrc_psc_div = 9'h001;
   localparam logic [7:0] pdrc_baud_div = 8'h07;
endpackage : pdrc_pkg

// ### pdrc_if.sv
`timescale 1ns/10ps
interface pdrc_if;
   logic sleep_indicator_out;
   logic reset_out;
   logic dma_req;
   logic hold_req;
   logic refresh_req;
   logic dma_grant;
   logic hold_grant;
   logic refresh_ack;
   logic wake_int;
   logic wake_nmi;
   logic system_mgmt_irq_n;
   logic data_in;
   logic data_out;
   logic data_oe;
   modport dev (
      output sleep_indicator_out,
      input reset_out,
      input dma_req,
      input hold_req,
      input refresh_req,
      output dma_grant,
      output hold_grant,
      output refresh_ack,
      input wake_int,
      input wake_nmi,
      input system_mgmt_irq_n,
      input data_in,
      output data_out,
      output data_oe
   );
   modport sys (
      input sleep_indicator_out,
      output reset_out,
      output dma_req,
      output hold_req,
      output refresh_req,
      input dma_grant,
      input hold_grant,
      input refresh_ack,
      output wake_int,
      output wake_nmi,
      output system_mgmt_irq_n,
      output data_in,
      input data_out,
      input data_oe
   );
endinterface : pdrc_if

// ### pdrc_system.sv
`timescale 1ns/10ps
module pdrc_system
   import pdrc_pkg::*;
(
   input wire logic mclk,
   input wire logic sys_rst,
   pdrc_if.sys link,
   input wire logic user_rst_req,
   input wire logic user_dma_req,
   input wire logic user_hold_req,
   input wire logic user_refresh_req,
   input wire logic user_int,
   input wire logic user_nmi,
   input wire logic user_smi,
   output logic ext_phase_one,
   output logic [1:0] ext_phase_state,
   output logic ext_rst_sync
);
   logic [4:0] rst_cnt;
   logic rst_meta;

   // stretch reset request to at least sixteen input clock cycles
   always_ff @(posedge mclk) begin
      if (sys_rst || user_rst_req) begin
         rst_cnt <= 5'h00;
      end else if (rst_cnt != pdrc_reset_cnt_max) begin
         rst_cnt <= rst_cnt + 5'h01;
      end
   end
   assign link.reset_out = (rst_cnt != pdrc_reset_cnt_max); // [RULE7]

   // dma and hold requests withheld while device sleeps
   assign link.dma_req = user_dma_req & ~link.sleep_indicator_out; // [RULE6]
   assign link.hold_req = user_hold_req & ~link.sleep_indicator_out; // [RULE6]
   assign link.refresh_req = user_refresh_req;
   assign link.wake_int = user_int;
   assign link.wake_nmi = user_nmi;
   assign link.system_mgmt_irq_n = ~user_smi;
   assign link.data_in = 1'b1;

   // synchronous reset for system components
   always_ff @(posedge mclk) begin
      rst_meta <= link.reset_out;
      ext_rst_sync <= rst_meta;
   end

   // phase clock generator
   always_ff @(posedge mclk) begin
      if (ext_rst_sync) begin
         ext_phase_state <= pdrc_ph_st0; // [RULE10]
      end else if (ext_phase_state == pdrc_ph_st0) begin
         ext_phase_state <= pdrc_ph_st1; // [RULE10]
      end else begin
         ext_phase_state <= pdrc_ph_st0; // [RULE10] [RULE11]
      end
   end
   assign ext_phase_one = (ext_phase_state != pdrc_ph_st1);
endmodule : pdrc_system

// ### pdrc_sva.sv
`timescale 1ns/10ps
module pdrc_sva
   import pdrc_pkg::*;
(
   input wire logic mclk,
   input wire logic sys_rst,
   input wire logic sleep_indicator_out,
   input wire logic reset_out,
   input wire logic dma_req,
   input wire logic dma_grant,
   input wire logic hold_grant,
   input wire logic refresh_ack,
   input wire logic wake_int,
   input wire logic wake_nmi,
   input wire logic system_mgmt_irq_n,
   input wire logic data_oe
);
   logic wk;
   logic [5:0] rcnt = 6'h00;
   // any wake-up level
   assign wk = wake_int | wake_nmi | ~system_mgmt_irq_n;
   // cycles the reset output has stood high
   always_ff @(posedge mclk) begin
      if (reset_out) begin
         rcnt <= rcnt + {5'h00, ~&rcnt};
      end else begin
         rcnt <= 6'h00;
      end
   end
   default clocking @(posedge mclk); endclocking
   default disable iff (sys_rst);
   sleep_grant_a: assert property (
      sleep_indicator_out && !wk && !$past(wk)
      |-> !(dma_grant | hold_grant | refresh_ack)) else $error("grant asleep");
   dma_cause_a: assert property (
      dma_grant |-> $past(dma_req)) else $error("grant without request");
   reset_len_a: assert property (
      $fell(reset_out) |-> rcnt >= 6'h10) else $error("reset too short");
   pin_float_a: assert property (disable iff (1'b0)
      sys_rst |-> !data_oe) else $error("pin driven in reset");
   wake_exit_a: assert property (
      sleep_indicator_out && wk |-> ##[1:6] !sleep_indicator_out)
      else $error("no exit on wake");
   entry_block_a: assert property (
      $rose(sleep_indicator_out) |-> !$past(wk, 2)) else $error("entry on wake");
   ind_hold_a: assert property (
      $rose(sleep_indicator_out) |=> sleep_indicator_out)
      else $error("indicator glitch");
endmodule : pdrc_sva

// ### tb_powerdown_reset_phase_clock.sv
`timescale 1ns/10ps
module tb_powerdown_reset_phase_clock;
   import pdrc_pkg::*;
   logic mclk = 1'b0, sys_rst = 1'b1, mode_wr = 1'b0, halt_cycle = 1'b0;
   logic ready_n = 1'b1, shared_port_pin_periph = 1'b1;
   logic drv = 1'b1, gpio = 1'b0;
   logic [1:0] mode_wdata = 2'h0;
   logic [6:0] usr = 7'h00;
   logic [1:0] pms, est;
   logic [3:0] hold;
   logic c1, c2, p1, p2, psc, sbc, prst, idl, pdn, eph1;
   int fail_count = 0, samples_checked = 0;
   pdrc_if lnk ();
   pdrc_device pdrc_device_inst (.mclk, .sys_rst, .link(lnk.dev), .mode_wr,
      .mode_wdata, .power_mode_select(pms), .halt_cycle, .ready_n,
      .shared_port_pin_periph, .shared_port_gpio(gpio), .core_drive(drv),
      .core_dout(1'b0), .core_phase_one_clock(c1), .core_phase_two_clock(c2),
      .periph_phase_one_clock(p1), .periph_phase_two_clock(p2),
      .prescaled_clock(psc), .serial_baud_clock(sbc), .periph_rst(prst),
      .in_idle(idl), .in_powerdown(pdn));
   // usr bits: reset, dma, hold, refresh, int, nmi, smi
   pdrc_system pdrc_system_inst (.mclk, .sys_rst, .link(lnk.sys),
      .user_rst_req(usr[0]), .user_dma_req(usr[1]), .user_hold_req(usr[2]),
      .user_refresh_req(usr[3]), .user_int(usr[4]), .user_nmi(usr[5]),
      .user_smi(usr[6]), .ext_phase_one(eph1), .ext_phase_state(est),
      .ext_rst_sync());
   pdrc_sva pdrc_sva_inst (.mclk, .sys_rst,
      .sleep_indicator_out(lnk.sleep_indicator_out), .reset_out(lnk.reset_out),
      .dma_req(lnk.dma_req), .dma_grant(lnk.dma_grant),
      .hold_grant(lnk.hold_grant), .refresh_ack(lnk.refresh_ack),
      .wake_int(lnk.wake_int), .wake_nmi(lnk.wake_nmi),
      .system_mgmt_irq_n(lnk.system_mgmt_irq_n), .data_oe(lnk.data_oe));
   // free-running 50 MHz clock
   initial begin
      forever #10 mclk = ~mclk;
   end
   task automatic end_sim;
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : end_sim
   task automatic chk(string nm, logic [3:0] exp, logic [3:0] got);
      samples_checked++;
      if (got !== exp) begin
         fail_count++;
         $display("unexpected %s expected %h seen %h", nm, exp, got);
      end
   endtask : chk
   task automatic cyc(int n);
      repeat (n) @(negedge mclk);
   endtask : cyc
   // write the mode field, then a halt ended by ready
   task automatic halt_with(logic [1:0] m);
      mode_wdata = m;
      mode_wr = 1'b1;
      cyc(1);
      mode_wr = 1'b0;
      chk("mode", {2'h0, m}, {2'h0, pms});
      halt_cycle = 1'b1;
      ready_n = 1'b0;
      cyc(1);
      halt_cycle = 1'b0;
      ready_n = 1'b1;
      cyc(3);
   endtask : halt_with
   task automatic t_pwr;
      int n;
      usr = 7'h0e;
      cyc(3);
      chk("dma_grant", 1, lnk.dma_grant);
      chk("hold refresh", 3, {lnk.hold_grant, lnk.refresh_ack});
      halt_with(pdrc_mode_sleep_indicator_out);
      chk("in_powerdown", 1, pdn);
      chk("indicator", 1, lnk.sleep_indicator_out);
      hold = {psc, sbc, 2'h0};
      cyc(4);
      chk("clocks", 4'h5, {c1, c2, p1, p2});
      chk("psc sbc", hold, {psc, sbc, 2'h0});
      chk("grants", 0, {lnk.dma_grant, lnk.hold_grant,
         lnk.refresh_ack});
      chk("dma hold req", 0, {lnk.dma_req, lnk.hold_req});
      usr[4] = 1'b1;
      n = 0;
      while (lnk.sleep_indicator_out !== 1'b0 && n < 20) begin
         cyc(1);
         n++;
      end
      usr[4] = 1'b0;
      chk("wake time", 1, n < 20);
      if (n >= 20) begin
         end_sim();
      end
      hold = {c1, p1, 2'h0};
      cyc(1);
      chk("restart", ~hold & 4'hc, {c1, p1, 2'h0});
      cyc(3);
      chk("dma_grant", 1, lnk.dma_grant);
      usr = 7'h00;
   endtask : t_pwr
   task automatic t_idle;
      halt_with(pdrc_mode_idle);
      hold = {2'h0, p1, 1'b0};
      cyc(1);
      chk("idle", {2'h1, ~hold[1], 1'b1}, {c1, c2, p1, idl});
      hold = {psc, 3'h0};
      cyc(int'(pdrc_psc_div) + 1);
      chk("psc run", ~hold & 4'h8, {psc, 3'h0});
      hold = {sbc, 3'h0};
      cyc(int'(pdrc_baud_div) + 1);
      chk("sbc run", ~hold & 4'h8, {sbc, 3'h0});
      usr[5] = 1'b1;
      cyc(3);
      chk("idle exit", 0, idl);
      usr[5] = 1'b0;
      usr[6] = 1'b1;
      cyc(2);
      halt_with(pdrc_mode_sleep_indicator_out);
      chk("blocked", 0, pdn);
      usr[6] = 1'b0;
      cyc(2);
      halt_with(pdrc_mode_active0);
      halt_with(pdrc_mode_active3);
      chk("active", 0, {idl, pdn});
      shared_port_pin_periph = 1'b0;
      gpio = 1'b1;
      cyc(2);
      chk("gpio pin", 1, lnk.sleep_indicator_out);
      gpio = 1'b0;
      shared_port_pin_periph = 1'b1;
      cyc(2);
      chk("gpio pin off", 0, lnk.sleep_indicator_out);
   endtask : t_idle
   task automatic t_rst;
      int n;
      halt_with(pdrc_mode_sleep_indicator_out);
      sys_rst = 1'b1;
      cyc(2);
      chk("reset exit", 0, {pdn, lnk.data_oe});
      sys_rst = 1'b0;
      cyc(4);
      chk("mode", 0, {pms, lnk.sleep_indicator_out});
      n = 0;
      usr[0] = 1'b1;
      cyc(1);
      usr[0] = 1'b0;
      repeat (40) begin
         if (lnk.reset_out === 1'b1) n++;
         cyc(1);
      end
      chk("reset_out len", 1, n >= pdrc_reset_min_cycles && n < 40);
      hold = {2'h0, est};
      cyc(1);
      chk("phase", {2'h0, pdrc_ph_st1 ^ hold[1:0]}, {2'h0, est});
      chk("phase one", {3'h0, est == pdrc_ph_st0}, {3'h0, eph1});
   endtask : t_rst
   initial begin
      cyc(10);
      chk("reset", 2, {prst, lnk.data_oe});
      sys_rst = 1'b0;
      cyc(4);
      chk("start", 0, {pms, prst});
      chk("drive", 1, lnk.data_oe);
      t_pwr();
      t_idle();
      t_rst();
      end_sim();
   end
endmodule : tb_powerdown_reset_phase_clock
